/* sipo_pkg.sv */
// constants shared by the serial-in parallel-out shifter
// assumes a single system clock; all pins are asynchronous to it
package sipo_pkg;
    localparam int          SIPO_STAGE_COUNT   = 8;
    localparam logic [7:0]  SIPO_STAGE_RESET   = 8'h00;
    localparam int          SIPO_SYNC_DEPTH    = 2;
    localparam int          SIPO_SYNC_WIDTH    = 3;
    // bit positions inside the synchronised pin bus
    localparam int          SIPO_PIN_CLOCK     = 2;
    localparam int          SIPO_PIN_A         = 1;
    localparam int          SIPO_PIN_B         = 0;
    localparam int          SIPO_CLK_FREQ_MHZ  = 50;
    // least level time of the shift clock pin, as seen by the sampler
    localparam int          SIPO_SCLK_LEVEL_NS = 40;
    localparam int          SIPO_SCLK_LEVEL_CYC =
        (SIPO_SCLK_LEVEL_NS * SIPO_CLK_FREQ_MHZ + 999) / 1000;
endpackage

/* sipo_sync.sv */
// parameterised two-flop synchroniser for asynchronous pin inputs
// assumes an active-low reset already synchronous to clk_sys
`timescale 1ns/100ps
module sipo_sync
    import sipo_pkg::*;
#(
    parameter int WIDTH = 1
)
(
    input  wire logic             clk_sys,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] async_in,
    output      logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] meta_d;
    logic [WIDTH-1:0] hold_q;
    logic [WIDTH-1:0] hold_d;

    always_comb
    begin
        meta_d = async_in;
        hold_d = meta_q;
    end

    // first stage is read by the second stage only
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta_q <= '0;
            hold_q <= '0;
        end
        else
        begin
            meta_q <= meta_d;
            hold_q <= hold_d;
        end
    end

    assign sync_out = hold_q;

endmodule

/* sipo_shifter.sv */
// eight-stage serial-in parallel-out shifter, sampled from the system clock
// assumes shift_clock holds each level for SIPO_SCLK_LEVEL_CYC clk_sys cycles
//
// Summary of operation
// R1: eight storage stages form a shift register, each shown on its own output.
// R2: serial entry goes through a two-input AND, captured on shift clock rising edges.
// R3: upstream holds one serial input high to enable the other, or low for zeros.
// R4: with one data source upstream ties the spare input high or joins both.
// R5: each shift clock rising edge moves every stage but the last into the next one.
// R6: first stage loads the AND of both serial inputs as they were before the edge.
// R7: clear low forces all stages low at once, ignoring clock and data inputs.
`timescale 1ns/100ps
module sipo_shifter
    import sipo_pkg::*;
#(
    parameter int STAGES = SIPO_STAGE_COUNT
)
(
    input  wire logic              clk_sys,
    input  wire logic              reset_n,
    input  wire logic              async_clear_n,
    input  wire logic              shift_clock,
    input  wire logic              serial_in_a,
    input  wire logic              serial_in_b,
    output      logic [STAGES-1:0] stage_outputs
);

    // reset release synchroniser
    logic [1:0]                 rst_q;
    logic [1:0]                 rst_d;
    logic                       rst_sync_n;

    // synchronised pin samples
    logic [SIPO_SYNC_WIDTH-1:0] pins_async;
    logic [SIPO_SYNC_WIDTH-1:0] pins_sync;
    logic                       sclk_s;
    logic                       data_a_s;
    logic                       data_b_s;

    // previous samples for edge detection and pre-edge data
    logic                       sclk_prev_q;
    logic                       sclk_prev_d;
    logic                       data_a_prev_q;
    logic                       data_a_prev_d;
    logic                       data_b_prev_q;
    logic                       data_b_prev_d;
    logic                       shift_fire;
    logic                       entry_bit;

    // the stages themselves
    logic [STAGES-1:0]          stage_q;
    logic [STAGES-1:0]          stage_d;

    always_comb
    begin
        rst_d = {rst_q[0], 1'b1};
    end

    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rst_q <= 2'h0;
        end
        else
        begin
            rst_q <= rst_d;
        end
    end

    assign rst_sync_n = rst_q[1];

    // clock and data share one chain so their samples stay aligned
    assign pins_async[SIPO_PIN_CLOCK] = shift_clock;
    assign pins_async[SIPO_PIN_A]     = serial_in_a;
    assign pins_async[SIPO_PIN_B]     = serial_in_b;

    sipo_sync #(
        .WIDTH    (SIPO_SYNC_WIDTH)
    ) u_pin_sync (
        .clk_sys  (clk_sys),
        .rst_n    (rst_sync_n),
        .async_in (pins_async),
        .sync_out (pins_sync)
    );

    assign sclk_s   = pins_sync[SIPO_PIN_CLOCK];
    assign data_a_s = pins_sync[SIPO_PIN_A];
    assign data_b_s = pins_sync[SIPO_PIN_B];

    always_comb
    begin
        sclk_prev_d   = sclk_s;
        data_a_prev_d = data_a_s;
        data_b_prev_d = data_b_s;
    end

    always_ff @(posedge clk_sys or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            sclk_prev_q   <= 1'b0;
            data_a_prev_q <= 1'b0;
            data_b_prev_q <= 1'b0;
        end
        else
        begin
            sclk_prev_q   <= sclk_prev_d;
            data_a_prev_q <= data_a_prev_d;
            data_b_prev_q <= data_b_prev_d;
        end
    end

    // rising edge seen on the sampled shift clock
    assign shift_fire = sclk_s & ~sclk_prev_q; // see R2
    // data taken from the sample before the edge, not the one with it
    assign entry_bit  = data_a_prev_q & data_b_prev_q; // see R2, see R6

    always_comb
    begin
        stage_d = stage_q;
        if (shift_fire)
        begin
            stage_d = {stage_q[STAGES-2:0], entry_bit}; // see R5, see R6
        end
    end

    // clear acts without the clock; a release near an edge may drop that shift
    always_ff @(posedge clk_sys or negedge rst_sync_n or negedge async_clear_n)
    begin
        if (!rst_sync_n || !async_clear_n)
        begin
            stage_q <= SIPO_STAGE_RESET[STAGES-1:0]; // see R7
        end
        else
        begin
            stage_q <= stage_d;
        end
    end

    assign stage_outputs = stage_q; // see R1

    // every stage after the first takes its neighbour on a shift
    property p_shift_moves;
        @(posedge clk_sys) disable iff (!rst_sync_n)
        shift_fire && async_clear_n ##1 async_clear_n
            |-> stage_q[STAGES-1:1] == $past(stage_q[STAGES-2:0]);
    endproperty
    a_shift_moves: assert property (p_shift_moves) // see R5
        else $error("stage did not take its neighbour on shift");

    // first stage gets the pre-edge AND of both inputs
    property p_entry_and;
        @(posedge clk_sys) disable iff (!rst_sync_n)
        shift_fire && async_clear_n ##1 async_clear_n
            |-> stage_q[0] == ($past(data_a_prev_q) & $past(data_b_prev_q));
    endproperty
    a_entry_and: assert property (p_entry_and) // see R6
        else $error("first stage did not load the anded serial inputs");

    // the first stage moves only after a detected rising edge
    property p_edge_only;
        @(posedge clk_sys) disable iff (!rst_sync_n)
        async_clear_n && $past(async_clear_n) && $changed(stage_q[0])
            |-> $past(shift_fire);
    endproperty
    a_edge_only: assert property (p_edge_only) // see R2
        else $error("first stage changed without a shift clock edge");

    // without a shift the whole register holds
    property p_hold;
        @(posedge clk_sys) disable iff (!rst_sync_n)
        !shift_fire && async_clear_n ##1 async_clear_n |-> $stable(stage_q);
    endproperty
    a_hold: assert property (p_hold) // see R1
        else $error("stages changed with no shift");

    // clear low means every stage reads low at each sampled edge
    property p_clear_zero;
        @(posedge clk_sys) disable iff (!rst_sync_n)
        !async_clear_n |-> stage_outputs == SIPO_STAGE_RESET[STAGES-1:0];
    endproperty
    a_clear_zero: assert property (p_clear_zero) // see R7
        else $error("stages not cleared while clear is low");

    // a held clear keeps the register empty even across shift edges
    property p_clear_hold;
        @(posedge clk_sys) disable iff (!rst_sync_n)
        (!async_clear_n) [*3] |-> ##0 stage_q == SIPO_STAGE_RESET[STAGES-1:0]
            && $past(stage_q, 2) == SIPO_STAGE_RESET[STAGES-1:0];
    endproperty
    a_clear_hold: assert property (p_clear_hold) // see R7
        else $error("stages not held zero while clear was held");

    // a pin rise is acted on once, after the two sync stages
    property p_edge_detect;
        @(posedge clk_sys) disable iff (!rst_sync_n)
        $rose(shift_clock) |-> ##[2:3] shift_fire ##1 !shift_fire;
    endproperty
    a_edge_detect: assert property (p_edge_detect) // see R2
        else $error("shift clock edge missed or repeated");

endmodule

/* sipo_up_model.sv */
// upstream logic model driving the shifter pins
// assumes clk_sys from the bench; pins move 2 ns after rising edges
`timescale 1ns/100ps
module sipo_up_model
(
    input  wire logic clk_sys,
    output      logic async_clear_n,
    output      logic shift_clock,
    output      logic serial_in_a,
    output      logic serial_in_b
);
    initial
    begin
        async_clear_n = 1'h1;
        shift_clock   = 1'h0;
        serial_in_a   = 1'h1;
        serial_in_b   = 1'h1;
    end

    // data set while clock low and held well past the rising edge
    task automatic shift_bit(input logic a, input logic b);
        @(posedge clk_sys);
        #2;
        serial_in_a = a;
        serial_in_b = b;
        repeat (3) @(posedge clk_sys);
        #2 shift_clock = 1'h1;
        // 3 cycles per level, above the sampler's least level time
        repeat (3) @(posedge clk_sys);
        #2 shift_clock = 1'h0;
        repeat (3) @(posedge clk_sys);
    endtask

    // data flips in the same step as the clock rise; only the old value may enter
    task automatic shift_bit_swap(input logic a, input logic b,
                                  input logic a2, input logic b2);
        @(posedge clk_sys);
        #2;
        serial_in_a = a;
        serial_in_b = b;
        repeat (3) @(posedge clk_sys);
        #2;
        shift_clock = 1'h1;
        serial_in_a = a2;
        serial_in_b = b2;
        repeat (3) @(posedge clk_sys);
        #2 shift_clock = 1'h0;
        repeat (3) @(posedge clk_sys);
    endtask

    task automatic set_clear(input logic v);
        @(posedge clk_sys);
        #2 async_clear_n = v;
    endtask
endmodule

/* sipo_shifter_tb.sv */
// self-checking bench for the serial-in parallel-out shifter
// assumes the upstream model in sipo_up_model drives every pin except clk_sys and reset_n, which the bench drives
`timescale 1ns/100ps
module sipo_shifter_tb;
    import sipo_pkg::*;
    logic       clk_sys;
    logic       reset_n;
    wire        async_clear_n;
    wire        shift_clock;
    wire        serial_in_a;
    wire        serial_in_b;
    logic [7:0] stage_outputs;
    logic [7:0] exp_q;
    int         failures;
    int         checks_done;
    int         cycles;

    initial clk_sys = 1'h0;
    always #10 clk_sys = ~clk_sys;

    sipo_up_model up (.clk_sys(clk_sys), .async_clear_n(async_clear_n),
        .shift_clock(shift_clock), .serial_in_a(serial_in_a), .serial_in_b(serial_in_b));
    sipo_shifter #(.STAGES(SIPO_STAGE_COUNT)) dut (.clk_sys(clk_sys), .reset_n(reset_n),
        .async_clear_n(async_clear_n), .shift_clock(shift_clock),
        .serial_in_a(serial_in_a), .serial_in_b(serial_in_b),
        .stage_outputs(stage_outputs));

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] want);
        checks_done++;
        if (seen !== want)
        begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", what, want, seen);
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic push(input logic a, input logic b);
        up.shift_bit(a, b);
        #1;
        exp_q = {exp_q[6:0], a & b};
        check("stages", stage_outputs, exp_q);
    endtask

    // one data input, the other tied high: pattern walks to stage 7
    task automatic t_walk();
        logic [7:0] pat;
        pat = 8'hB5;
        for (int i = 7; i >= 0; i--)
            push(pat[i], 1'h1);
        check("full pattern", stage_outputs, 8'hB5);
    endtask

    // every gate combination, then B low forcing zeros
    task automatic t_gate();
        push(1'h1, 1'h1);
        push(1'h1, 1'h0);
        push(1'h0, 1'h1);
        push(1'h0, 1'h0);
        push(1'h1, 1'h1);
        for (int i = 0; i < 3; i++)
            push(1'h1, 1'h0);
    endtask

    // data flips together with the clock rise: the pre-edge value must enter
    task automatic t_pre_edge();
        up.shift_bit_swap(1'h1, 1'h1, 1'h0, 1'h1);
        #1;
        exp_q = {exp_q[6:0], 1'h1};
        check("pre-edge one", stage_outputs, exp_q);
        up.shift_bit_swap(1'h0, 1'h1, 1'h1, 1'h1);
        #1;
        exp_q = {exp_q[6:0], 1'h0};
        check("pre-edge zero", stage_outputs, exp_q);
    endtask

    // clear in mid-run, shift while held, then one shift after release
    task automatic t_clear();
        push(1'h1, 1'h1);
        up.set_clear(1'h0);
        #1;
        check("clear at once", stage_outputs, 8'h00);
        up.shift_bit(1'h1, 1'h1);
        check("shift ignored", stage_outputs, 8'h00);
        up.set_clear(1'h1);
        repeat (6) @(posedge clk_sys);
        exp_q = 8'h00;
        push(1'h1, 1'h1);
        check("one shift after clear", stage_outputs, 8'h01);
    endtask

    // ceiling well above the roughly 245 cycles the scenarios need
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            failures++;
            end_of_test();
        end
    end

    initial
    begin
        reset_n = 1'h0;
        failures = 0;
        checks_done = 0;
        cycles = 0;
        exp_q = SIPO_STAGE_RESET;
        repeat (20) @(posedge clk_sys);
        #2 reset_n = 1'h1;
        repeat (6) @(posedge clk_sys);
        check("after reset", stage_outputs, SIPO_STAGE_RESET);
        t_walk();
        t_gate();
        t_pre_edge();
        t_clear();
        end_of_test();
    end
endmodule
